/* File: oad_map.svh */
// oad_map.svh: numeric constants of the operand address decoder.
// assumes it is included by bare name wherever offsets or counts are needed.
`ifndef OAD_MAP_SVH
`define OAD_MAP_SVH

// prefix bytes that stand in front of an opcode
`define OAD_PFX_SECOND_REG 8'h90
`define OAD_PFX_SECOND_IND 8'h91
`define OAD_PFX_INDIRECT 8'h92

// instruction length pieces, in bytes
`define OAD_LEN_OPCODE 3'h1
`define OAD_LEN_PREFIX 3'h1
`define OAD_LEN_BITREL 3'h1

// page zero high byte and interrupt mask levels
`define OAD_PAGE_ZERO 8'h00
`define OAD_MASK_HIGH 2'h3
`define OAD_MASK_LOW 2'h0
`define OAD_MASK_RESET 2'h3

`endif

/* File: oad_pkg.sv */
// oad_pkg: types shared by the operand address decoder and its users.
// assumes nothing beyond a SystemVerilog compiler.
package oad_pkg;

  // the seventeen addressing modes, in their seven groups
  typedef enum logic [4:0] {
    M_INH = 5'h00,
    M_IMM = 5'h01,
    M_DIR_S = 5'h02,
    M_DIR_L = 5'h03,
    M_IDX_0 = 5'h04,
    M_IDX_S = 5'h05,
    M_IDX_L = 5'h06,
    M_IND_S = 5'h07,
    M_IND_L = 5'h08,
    M_INDX_S = 5'h09,
    M_INDX_L = 5'h0A,
    M_REL_D = 5'h0B,
    M_REL_I = 5'h0C,
    M_BIT_D = 5'h0D,
    M_BIT_I = 5'h0E,
    M_BITREL_D = 5'h0F,
    M_BITREL_I = 5'h10
  } oad_mode_t;

  typedef enum logic [2:0] {
    OP_PLAIN = 3'h0,
    OP_MASK_SET = 3'h1,
    OP_MASK_CLEAR = 3'h2,
    OP_HALT = 3'h3,
    OP_WAIT_IRQ = 3'h4
  } oad_opclass_t;

  typedef struct packed {
    oad_mode_t mode;
    oad_opclass_t opClass;
    logic rmw;
    logic prefixValid;
    logic [7:0] prefixByte;
    logic [15:0] pc;
    logic [7:0] idxPrimary;
    logic [7:0] idxSecond;
  } oad_req_t;

  typedef struct packed {
    logic [15:0] effAddr;
    logic [15:0] relTarget;
    logic [2:0] instrLen;
    logic badMode;
  } oad_result_t;

endpackage : oad_pkg

/* File: oad_decoder.sv */
// oad_decoder: forms instruction length and operand address for each addressing mode.
// assumes a byte read port to program/data memory that answers with memValid,
// and a fetch unit that hands over the opcode's mode, prefix, pc and index registers.
`timescale 1ns/1ns
`default_nettype none
`include "oad_map.svh"

// How it works
// RULE1: seventeen addressing modes in seven groups are decoded from the request.
// RULE2: long forms take extra bytes and cycles and reach all 64 Kbyte.
// RULE3: short forms address page zero only, 0000h to 00FFh; short indexed and short indirect indexed sums reach up to 01FEh.
// RULE4: read-modify-write ops in a long form are flagged as a bad mode.
// RULE5: inherent instructions are one byte, with no operand fetch.
// RULE6: immediate instructions are two bytes, operand right after opcode.
// RULE7: short direct uses one address byte as the page-zero address.
// RULE8: long direct uses a two-byte address word after the opcode.
// RULE9: indexed modes add the selected index register unsigned to the offset.
// RULE10: indexed without offset fetches nothing and uses the index alone.
// RULE11: short indexed sums byte offset and index up to 1FE, no wrap.
// RULE12: long indexed adds the index to a two-byte offset word.
// RULE13: indirect modes read a pointer from memory and use it as address.
// RULE14: short indirect reads a byte pointer from a page-zero address.
// RULE15: long indirect reads a word pointer from a page-zero address.
// RULE16: mask set op raises mask to 3, mask clear op lowers it to 0.
// RULE17: halt stops the oscillator; wait-for-irq idles until an interrupt.
// RULE18: indirect indexed adds the index to a byte or word pointer.
// RULE19: relative direct adds a signed offset byte to the program counter.
// RULE20: relative indirect reads the signed offset from memory.
// RULE21: prefixes 90, 92, 91 select second register, indirect, second indirect.
// RULE22: in a two-byte word the lower address byte is the high byte.
// RULE23: instruction length is reported so fetch skips every operand byte.
module oad_decoder
  import oad_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // request from fetch
  input wire logic reqValid,
  input wire oad_req_t req,
  output logic reqReady,
  // result to execute and fetch
  output logic resDone,
  output oad_result_t res,
  // memory byte read port
  output logic memReq,
  output logic [15:0] memAddr,
  input wire logic memValid,
  input wire logic [7:0] memData,
  // power and interrupt state
  input wire logic irqPending,
  output logic [1:0] maskLevel,
  output logic oscStop,
  output logic waitIdle
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPND1 = 6'h02,
    ST_OPND2 = 6'h04,
    ST_PTR1 = 6'h08,
    ST_PTR2 = 6'h10,
    ST_DONE = 6'h20
  } oad_state_t;

  oad_state_t state_r, state_nxt;
  oad_mode_t mode_r;
  oad_opclass_t opClass_r;
  logic [15:0] pc_r, memAddr_r, memAddr_nxt;
  logic [7:0] idx_r, opnd1_r, opnd2_r, ptrHi_r, ptrLo_r;
  logic [2:0] len_r;
  logic rmw_r;
  logic [1:0] maskLevel_r;
  logic oscStop_r, waitIdle_r;
  logic resDone_r;
  oad_result_t res_r;

  // prefix folding: 92 turns direct/offset-indexed/relative/bit forms indirect, 91 turns only offset-indexed forms indirect with the second register
  wire logic pfx2 = req.prefixValid && (req.prefixByte == `OAD_PFX_SECOND_REG);
  wire logic pfx1 = req.prefixValid && (req.prefixByte == `OAD_PFX_SECOND_IND);
  wire logic pfxI = req.prefixValid && (req.prefixByte == `OAD_PFX_INDIRECT);
  oad_mode_t foldMode;
  // RULE21: prefix mode folding
  always_comb begin
    foldMode = req.mode;
    if (pfxI) begin
      case (req.mode)
        M_DIR_S: foldMode = M_IND_S;
        M_DIR_L: foldMode = M_IND_L;
        M_IDX_S: foldMode = M_INDX_S;
        M_IDX_L: foldMode = M_INDX_L;
        M_REL_D: foldMode = M_REL_I;
        M_BIT_D: foldMode = M_BIT_I;
        M_BITREL_D: foldMode = M_BITREL_I;
        default: foldMode = req.mode;
      endcase
    end else if (pfx1) begin
      case (req.mode)
        M_IDX_S: foldMode = M_INDX_S;
        M_IDX_L: foldMode = M_INDX_L;
        default: foldMode = req.mode;
      endcase
    end
  end

  // RULE1: mode groups decide operand bytes
  wire logic twoOpnd = (foldMode == M_DIR_L) || (foldMode == M_IDX_L);
  wire logic noOpnd = (foldMode == M_INH) || (foldMode == M_IDX_0);
  wire logic [2:0] opndLen = noOpnd ? 3'h0 : (twoOpnd ? 3'h2 : 3'h1);
  wire logic bitRel = (foldMode == M_BITREL_D) || (foldMode == M_BITREL_I);
  // RULE23: length counts prefix, opcode, operands
  wire logic [2:0] reqLen = `OAD_LEN_OPCODE + opndLen + (req.prefixValid ? `OAD_LEN_PREFIX : 3'h0)
    + (bitRel ? `OAD_LEN_BITREL : 3'h0);
  // RULE21: second register selection
  wire logic [7:0] reqIdx = (pfx2 || pfx1) ? req.idxSecond : req.idxPrimary;
  wire logic [15:0] opndAddr = req.pc + (req.prefixValid ? 16'h0002 : 16'h0001);

  // decoding of the latched mode
  wire logic ptrMode = (mode_r == M_IND_S) || (mode_r == M_IND_L) || (mode_r == M_INDX_S)
    || (mode_r == M_INDX_L) || (mode_r == M_REL_I) || (mode_r == M_BIT_I) || (mode_r == M_BITREL_I);
  wire logic ptrWord = (mode_r == M_IND_L) || (mode_r == M_INDX_L);
  wire logic longMode = (mode_r == M_DIR_L) || (mode_r == M_IDX_L) || (mode_r == M_IND_L)
    || (mode_r == M_INDX_L);
  wire logic needOpnd2 = (mode_r == M_DIR_L) || (mode_r == M_IDX_L);

  assign reqReady = (state_r == ST_IDLE);
  assign memReq = (state_r == ST_OPND1) || (state_r == ST_OPND2) || (state_r == ST_PTR1)
    || (state_r == ST_PTR2);
  assign memAddr = memAddr_r;
  assign resDone = resDone_r;
  assign res = res_r;
  assign maskLevel = maskLevel_r;
  assign oscStop = oscStop_r;
  assign waitIdle = waitIdle_r;

  // RULE13: pointer fetch sequence
  always_comb begin
    state_nxt = state_r;
    memAddr_nxt = memAddr_r;
    case (state_r)
      ST_IDLE: begin
        if (reqValid) begin
          memAddr_nxt = opndAddr;
          // RULE5: no operand fetch
          state_nxt = noOpnd ? ST_DONE : ST_OPND1;
        end
      end
      ST_OPND1: begin
        if (memValid) begin
          if (needOpnd2) begin
            memAddr_nxt = memAddr_r + 16'h0001;
            state_nxt = ST_OPND2;
          end else if (ptrMode) begin
            // RULE14: pointer address on page zero
            memAddr_nxt = {`OAD_PAGE_ZERO, memData};
            state_nxt = ST_PTR1;
          end else begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_OPND2: begin
        if (memValid) begin
          state_nxt = ST_DONE;
        end
      end
      ST_PTR1: begin
        if (memValid) begin
          // RULE15: word pointer takes a second byte
          if (ptrWord) begin
            memAddr_nxt = {`OAD_PAGE_ZERO, memAddr_r[7:0] + 8'h01};
            state_nxt = ST_PTR2;
          end else begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_PTR2: begin
        if (memValid) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // effective address per mode
  wire logic [15:0] idx16 = {8'h00, idx_r};
  wire logic [15:0] pcNext = pc_r + {13'h0000, len_r};
  wire logic [15:0] ptrWordVal = {ptrHi_r, ptrLo_r};
  wire logic [15:0] ptrByteVal = {`OAD_PAGE_ZERO, ptrHi_r};
  oad_result_t res_nxt;
  always_comb begin
    res_nxt = res_r;
    res_nxt.instrLen = len_r;
    res_nxt.relTarget = pcNext;
    // RULE4: long forms refused for read-modify-write
    res_nxt.badMode = rmw_r && longMode;
    case (mode_r)
      M_INH: res_nxt.effAddr = 16'h0000;
      // RULE6: operand sits right after opcode
      M_IMM: res_nxt.effAddr = pc_r + {13'h0000, len_r} - 16'h0001;
      // RULE7: short direct, RULE3 page zero
      M_DIR_S, M_BIT_D, M_BITREL_D: res_nxt.effAddr = {`OAD_PAGE_ZERO, opnd1_r};
      // RULE8: long direct, RULE22 high byte first, RULE2 full space
      M_DIR_L: res_nxt.effAddr = {opnd1_r, opnd2_r};
      // RULE10: index alone
      M_IDX_0: res_nxt.effAddr = idx16;
      // RULE11: 9-bit sum kept, RULE9 unsigned add
      M_IDX_S: res_nxt.effAddr = {`OAD_PAGE_ZERO, opnd1_r} + idx16;
      // RULE12: long offset plus index
      M_IDX_L: res_nxt.effAddr = {opnd1_r, opnd2_r} + idx16;
      // RULE14: byte pointer
      M_IND_S, M_BIT_I, M_BITREL_I: res_nxt.effAddr = ptrByteVal;
      // RULE15: word pointer
      M_IND_L: res_nxt.effAddr = ptrWordVal;
      // RULE18: pointer plus index
      M_INDX_S: res_nxt.effAddr = ptrByteVal + idx16;
      M_INDX_L: res_nxt.effAddr = ptrWordVal + idx16;
      // RULE19: signed offset from operand byte
      M_REL_D: begin
        res_nxt.effAddr = pcNext;
        res_nxt.relTarget = pcNext + {{8{opnd1_r[7]}}, opnd1_r};
      end
      // RULE20: signed offset read from memory
      M_REL_I: begin
        res_nxt.effAddr = ptrByteVal;
        res_nxt.relTarget = pcNext + {{8{ptrHi_r[7]}}, ptrHi_r};
      end
      default: res_nxt.effAddr = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      memAddr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      memAddr_r <= memAddr_nxt;
    end
  end

  // request capture
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_r <= M_INH;
      opClass_r <= OP_PLAIN;
      pc_r <= 16'h0000;
      idx_r <= 8'h00;
      len_r <= 3'h0;
      rmw_r <= 1'b0;
    end else if (reqReady && reqValid) begin
      mode_r <= foldMode;
      opClass_r <= req.opClass;
      pc_r <= req.pc;
      idx_r <= reqIdx;
      len_r <= reqLen;
      rmw_r <= req.rmw;
    end
  end

  // operand and pointer bytes; the first fetched byte of a two-byte word lands in the high byte
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      opnd1_r <= 8'h00;
      opnd2_r <= 8'h00;
      ptrHi_r <= 8'h00;
      ptrLo_r <= 8'h00;
    end else if (memValid) begin
      if (state_r == ST_OPND1) opnd1_r <= memData;
      if (state_r == ST_OPND2) opnd2_r <= memData;
      // RULE22: first pointer byte is high
      if (state_r == ST_PTR1) ptrHi_r <= memData;
      if (state_r == ST_PTR2) ptrLo_r <= memData;
    end
  end

  // result is formed in the done state, once the last fetched byte and the request have landed
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      res_r <= '0;
      resDone_r <= 1'b0;
    end else begin
      resDone_r <= (state_r == ST_DONE);
      if (state_r == ST_DONE) res_r <= res_nxt;
    end
  end

  // mask and power state act when the instruction completes; reset leaves the mask raised
  wire logic doneOp = (state_r == ST_DONE);
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      maskLevel_r <= `OAD_MASK_RESET;
      oscStop_r <= 1'b0;
      waitIdle_r <= 1'b0;
    end else begin
      // RULE16: mask set and clear
      if (doneOp && opClass_r == OP_MASK_SET) maskLevel_r <= `OAD_MASK_HIGH;
      else if (doneOp && opClass_r == OP_MASK_CLEAR) maskLevel_r <= `OAD_MASK_LOW;
      // RULE17: halt and wait, left by an interrupt
      if (doneOp && opClass_r == OP_HALT) oscStop_r <= 1'b1;
      else if (irqPending) oscStop_r <= 1'b0;
      if (doneOp && opClass_r == OP_WAIT_IRQ) waitIdle_r <= 1'b1;
      else if (irqPending) waitIdle_r <= 1'b0;
    end
  end

  property p_inh_len;
    @(posedge mclk) disable iff (!reset_n)
    reqReady && reqValid && req.mode == M_INH && !req.prefixValid |-> ##2 resDone && res.instrLen == 3'h1;
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent length not one"); // RULE5

  property p_imm_len;
    @(posedge mclk) disable iff (!reset_n)
    resDone && mode_r == M_IMM |-> (res.instrLen == 3'h2 || res.instrLen == 3'h3)
      && res.effAddr == pc_r + {13'h0000, res.instrLen} - 16'h0001;
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate operand address wrong"); // RULE6

  property p_dir_page0;
    @(posedge mclk) disable iff (!reset_n)
    resDone && mode_r == M_DIR_S |-> res.effAddr[15:8] == 8'h00 && res.effAddr[7:0] == opnd1_r;
  endproperty
  a_dir_page0: assert property (p_dir_page0) else $error("short direct left page zero"); // RULE7

  property p_idx0_nofetch;
    @(posedge mclk) disable iff (!reset_n)
    reqReady && reqValid && req.mode == M_IDX_0 |=> !memReq ##1 resDone && !memReq;
  endproperty
  a_idx0_nofetch: assert property (p_idx0_nofetch) else $error("indexed no offset fetched"); // RULE10

  property p_idx_s_range;
    @(posedge mclk) disable iff (!reset_n)
    resDone && mode_r == M_IDX_S |-> res.effAddr <= 16'h01FE && res.effAddr == {8'h00, opnd1_r} + idx16;
  endproperty
  a_idx_s_range: assert property (p_idx_s_range) else $error("short indexed sum wrong"); // RULE11

  property p_mask_set;
    @(posedge mclk) disable iff (!reset_n)
    resDone && opClass_r == OP_MASK_SET |=> maskLevel == 2'h3;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not raised to 3"); // RULE16

  property p_rmw_long;
    @(posedge mclk) disable iff (!reset_n)
    resDone && rmw_r && (mode_r == M_DIR_L || mode_r == M_IDX_L) |-> res.badMode;
  endproperty
  a_rmw_long: assert property (p_rmw_long) else $error("long rmw not flagged"); // RULE4

  property p_mem_hold;
    @(posedge mclk) disable iff (!reset_n)
    memReq && !memValid |=> memReq && $stable(memAddr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped"); // RULE13

  property p_word_msb;
    @(posedge mclk) disable iff (!reset_n)
    resDone && mode_r == M_IND_L |-> res.effAddr == {ptrHi_r, ptrLo_r};
  endproperty
  a_word_msb: assert property (p_word_msb) else $error("word pointer byte order wrong"); // RULE22

  property p_rel_target;
    @(posedge mclk) disable iff (!reset_n)
    resDone && mode_r == M_REL_D |-> res.relTarget == pcNext + {{8{opnd1_r[7]}}, opnd1_r};
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target wrong"); // RULE19

endmodule : oad_decoder
`default_nettype wire

/* File: oad_mem_model.sv */
// oad_mem_model: byte-wide program/data memory behind the decoder's read port.
// assumes the decoder holds memReq and memAddr steady until memValid is seen.
`timescale 1ns/1ns
`default_nettype none
module oad_mem_model (
  // clock
  input wire logic mclk,
  // read port
  input wire logic memReq,
  input wire logic [15:0] memAddr,
  output logic memValid,
  output logic [7:0] memData,
  // wait cycles before the answer, 0 answers in the request cycle
  input wire logic [1:0] latency
);
  logic [7:0] mem [0:65535];
  logic [1:0] waitCnt_r = 2'h0;
  logic [7:0] lastData_r = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  assign memValid = memReq && (waitCnt_r == latency);
  // off an answer the bus shows a stale inverse, so a late sample cannot match by luck
  assign memData = memValid ? mem[memAddr] : ~lastData_r;
  always @(posedge mclk) begin
    waitCnt_r <= (!memReq || memValid) ? 2'h0 : waitCnt_r + 2'h1;
    if (memValid) begin
      lastData_r <= mem[memAddr];
    end
  end
endmodule : oad_mem_model
`default_nettype wire

/* File: oad_tb_top.sv */
// oad_tb_top: self-checking bench for the operand address decoder.
// assumes oad_pkg is compiled first and the memory model answers the read port.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import oad_pkg::*;
  logic mclk, reset_n, reqValid, reqReady, resDone, memReq, memValid, irqPending, oscStop, waitIdle;
  logic [15:0] memAddr;
  logic [7:0] memData;
  logic [1:0] maskLevel, latency;
  oad_req_t req;
  oad_result_t res, got;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  oad_decoder u_dut (
    .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .resDone(resDone), .res(res), .memReq(memReq), .memAddr(memAddr), .memValid(memValid),
    .memData(memData), .irqPending(irqPending), .maskLevel(maskLevel), .oscStop(oscStop),
    .waitIdle(waitIdle)
  );
  oad_mem_model u_mem (
    .mclk(mclk), .memReq(memReq), .memAddr(memAddr), .memValid(memValid), .memData(memData),
    .latency(latency)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // a hang far beyond the hundred or so cycles needed ends the run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk

  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    u_mem.mem[a] = v;
  endtask : poke

  task automatic issue(input oad_mode_t m, input oad_opclass_t oc, input logic rmw, input logic [7:0] pfx,
      input logic [15:0] pc, input logic [7:0] ix, input logic [7:0] iy);
    int n;
    @(posedge mclk);
    req <= '{mode: m, opClass: oc, rmw: rmw, prefixValid: (pfx != 8'h00), prefixByte: pfx, pc: pc,
             idxPrimary: ix, idxSecond: iy};
    reqValid <= 1'b1;
    @(posedge mclk);
    reqValid <= 1'b0;
    #1;
    for (n = 0; n < 40 && resDone !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    got = res;
    chk({15'h0000, resDone}, 16'h0001);
  endtask : issue

  task automatic cr(input logic [15:0] eff, input logic [15:0] len);
    chk(got.effAddr, eff);
    chk(16'(got.instrLen), len);
  endtask : cr

  task automatic t_reset();
    #1;
    chk(16'(maskLevel), 16'h0003);
    chk({14'h0000, oscStop, waitIdle}, 16'h0000);
    chk({15'h0000, reqReady}, 16'h0001);
    chk({14'h0000, resDone, memReq}, 16'h0000);
  endtask : t_reset

  task automatic t_inherent();
    issue(M_INH, OP_MASK_CLEAR, 1'b0, 8'h00, 16'h0100, 8'h00, 8'h00);
    cr(16'h0000, 16'h0001);
    @(posedge mclk);
    #1;
    chk(16'(maskLevel), 16'h0000);
    issue(M_INH, OP_MASK_SET, 1'b0, 8'h00, 16'h0100, 8'h00, 8'h00);
    @(posedge mclk);
    #1;
    chk(16'(maskLevel), 16'h0003);
    poke(16'h0111, 8'h55);
    issue(M_IMM, OP_PLAIN, 1'b0, 8'h00, 16'h0110, 8'h00, 8'h00);
    cr(16'h0111, 16'h0002);
  endtask : t_inherent

  task automatic t_direct();
    latency <= 2'h2;
    poke(16'h0311, 8'hAB);
    issue(M_DIR_S, OP_PLAIN, 1'b0, 8'h00, 16'h0310, 8'h00, 8'h00);
    cr(16'h00AB, 16'h0002);
    poke(16'h0301, 8'h12);
    poke(16'h0302, 8'h34);
    issue(M_DIR_L, OP_PLAIN, 1'b0, 8'h00, 16'h0300, 8'h00, 8'h00);
    cr(16'h1234, 16'h0003);
    latency <= 2'h0;
  endtask : t_direct

  task automatic t_indexed();
    issue(M_IDX_0, OP_PLAIN, 1'b0, 8'h00, 16'h0390, 8'h5C, 8'h00);
    cr(16'h005C, 16'h0001);
    poke(16'h0401, 8'hFF);
    issue(M_IDX_S, OP_PLAIN, 1'b0, 8'h00, 16'h0400, 8'hFF, 8'h00);
    cr(16'h01FE, 16'h0002);
    poke(16'h0502, 8'hF0);
    poke(16'h0503, 8'h10);
    issue(M_IDX_L, OP_PLAIN, 1'b0, 8'h90, 16'h0500, 8'h01, 8'h20);
    cr(16'hF030, 16'h0004);
  endtask : t_indexed

  task automatic t_indirect();
    poke(16'h0602, 8'h30);
    poke(16'h0030, 8'hC7);
    issue(M_DIR_S, OP_PLAIN, 1'b0, 8'h92, 16'h0600, 8'h00, 8'h00);
    cr(16'h00C7, 16'h0003);
    // pointer address FF: the low byte comes from 00, wrapping in page zero
    poke(16'h0702, 8'hFF);
    poke(16'h00FF, 8'hBE);
    poke(16'h0000, 8'hEF);
    issue(M_DIR_L, OP_PLAIN, 1'b0, 8'h92, 16'h0700, 8'h00, 8'h00);
    cr(16'hBEEF, 16'h0003);
    poke(16'h0802, 8'h60);
    poke(16'h0060, 8'hF0);
    issue(M_IDX_S, OP_PLAIN, 1'b0, 8'h91, 16'h0800, 8'h01, 8'h20);
    cr(16'h0110, 16'h0003);
    poke(16'h0902, 8'h70);
    poke(16'h0070, 8'h12);
    poke(16'h0071, 8'hFF);
    issue(M_IDX_L, OP_PLAIN, 1'b0, 8'h92, 16'h0900, 8'h03, 8'h40);
    cr(16'h1302, 16'h0003);
  endtask : t_indirect

  task automatic t_relative();
    poke(16'h1001, 8'h80);
    issue(M_REL_D, OP_PLAIN, 1'b0, 8'h00, 16'h1000, 8'h00, 8'h00);
    chk(got.relTarget, 16'h0F82);
    poke(16'h2002, 8'h40);
    poke(16'h0040, 8'h7F);
    issue(M_REL_D, OP_PLAIN, 1'b0, 8'h92, 16'h2000, 8'h00, 8'h00);
    chk(got.relTarget, 16'h2082);
    chk(16'(got.instrLen), 16'h0003);
  endtask : t_relative

  task automatic t_bit();
    poke(16'h1101, 8'h22);
    issue(M_BITREL_D, OP_PLAIN, 1'b0, 8'h00, 16'h1100, 8'h00, 8'h00);
    cr(16'h0022, 16'h0003);
    poke(16'h1202, 8'h50);
    poke(16'h0050, 8'h33);
    issue(M_BIT_D, OP_PLAIN, 1'b0, 8'h92, 16'h1200, 8'h00, 8'h00);
    cr(16'h0033, 16'h0003);
  endtask : t_bit

  task automatic t_rmw();
    issue(M_DIR_L, OP_PLAIN, 1'b1, 8'h00, 16'h0300, 8'h00, 8'h00);
    chk({15'h0000, got.badMode}, 16'h0001);
    issue(M_DIR_S, OP_PLAIN, 1'b1, 8'h00, 16'h0310, 8'h00, 8'h00);
    chk({15'h0000, got.badMode}, 16'h0000);
  endtask : t_rmw

  task automatic t_power();
    issue(M_INH, OP_HALT, 1'b0, 8'h00, 16'h0120, 8'h00, 8'h00);
    @(posedge mclk);
    irqPending <= 1'b1;
    #1;
    chk({14'h0000, oscStop, waitIdle}, 16'h0002);
    @(posedge mclk);
    irqPending <= 1'b0;
    #1;
    chk({14'h0000, oscStop, waitIdle}, 16'h0000);
    issue(M_INH, OP_WAIT_IRQ, 1'b0, 8'h00, 16'h0121, 8'h00, 8'h00);
    @(posedge mclk);
    irqPending <= 1'b1;
    #1;
    chk({14'h0000, oscStop, waitIdle}, 16'h0001);
    @(posedge mclk);
    irqPending <= 1'b0;
    #1;
    chk({14'h0000, oscStop, waitIdle}, 16'h0000);
  endtask : t_power

  initial begin
    reset_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    irqPending = 1'b0;
    latency = 2'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_inherent();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_rmw();
    t_power();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
